/* hdl/sbsram_defines.vh */
`ifndef SBSRAM_DEFINES_VH
`define SBSRAM_DEFINES_VH
`define SBS_ADDR_W 19
`define SBS_DATA_W 16
`define SBS_LANES 2
`define SBS_LANE_W 8
`define SBS_DEPTH 524288
`define SBS_BURST_W 2
`define SBS_BURST_ONE 2'h1
`define SBS_BURST_ZERO 2'h0
`define SBS_RESET_SYNC 2'h0
`endif

/* hdl/sbsram_mem.v */
`timescale 1ns/1ps
module sbsram_mem (
  input wire clk,
  input wire [18:0] waddr,
  input wire [8:0] wdata,
  input wire we,
  input wire [18:0] raddr,
  output reg [8:0] rdata
);
  reg [8:0] mem [0:524287];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* hdl/sbsram_burst.v */
`timescale 1ns/1ps
`include "sbsram_defines.vh"
module sbsram_burst (
  input wire clk,
  input wire rst_q_n,
  input wire load,
  input wire [1:0] load_val,
  input wire advance,
  input wire interleave,
  output wire [1:0] offset
);
  reg [1:0] base;
  reg [1:0] count;
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      base <= `SBS_BURST_ZERO;
      count <= `SBS_BURST_ZERO;
    end else if (load) begin
      base <= load_val;
      count <= `SBS_BURST_ZERO;
    end else if (advance) begin
      count <= count + `SBS_BURST_ONE;
    end
  end
  // Wraps within four
  assign offset = interleave ? (base ^ count) : (base + count); // [R13]
endmodule

/* hdl/sbsram_top.v */
// Summary of operation
// [R1] A low controller strobe on a clock edge captures the address and loads bits 1:0 into the burst counter.
// [R2] When both strobes are active together only the processor strobe is acted on; with chip enable high the controller strobe is acted on instead.
// [R3] A high sleep input holds the device idle while all contents are kept.
// [R4] Sleep must be low or open for normal use; an open sleep pin reads low through a pull-down.
// [R5] Input data lines are captured into a data register on the rising edge.
// [R6] A read drives the word addressed at an edge during the cycle after the second edge that follows it.
// [R7] Data and parity are driven only while output enable is low, else released.
// [R8] Outputs stay released while deselected and during the first clock after leaving deselect.
// [R9] Parity lines behave as data and each is written only under its own lane write select.
// [R10] A grounded burst-order strap gives linear burst order.
// [R11] A high or open strap gives interleaved order via a pull-up.
// [R12] The other party keeps the strap static during operation.
// [R13] The two-bit burst counter wraps in four; linear adds, interleaved XORs a count of 0 to 3.
`timescale 1ns/1ps
`include "sbsram_defines.vh"
module sbsram_top (
  input wire clk,
  input wire rst_n,
  input wire [18:0] addr,
  input wire controller_address_strobe_n,
  input wire processor_address_strobe_n,
  input wire advance_n,
  input wire chip_enable_n,
  input wire write_enable_n,
  input wire [1:0] byte_lane_write_select_n,
  input wire output_enable_n,
  input wire sleep_request,
  input wire sleep_connected,
  input wire burst_order,
  input wire burst_order_connected,
  input wire [15:0] data_in,
  output reg [15:0] data_out,
  output reg data_oe_n,
  input wire [1:0] parity_data_lines_in,
  output reg [1:0] parity_data_lines_out,
  output reg parity_oe_n,
  output reg sleeping
);
  reg [1:0] rst_sync;
  wire rst_q_n;
  reg [1:0] sleep_sync;
  reg [1:0] oe_sync;
  reg [1:0] strap_sync;
  reg interleave;
  reg strap_taken;
  reg [18:0] addr_reg;
  reg selected;
  reg was_deselected;
  reg reading;
  reg [15:0] wdata_reg;
  reg [1:0] wpar_reg;
  reg [1:0] lane_we;
  reg [18:0] wr_addr;
  wire sleep_lvl;
  wire cas_n;
  wire pas;
  wire cas;
  wire strobe;
  wire [1:0] offset;
  wire [18:0] cur_addr;
  wire [8:0] rd0;
  wire [8:0] rd1;
  wire strap_lvl;
  reg next_drive;
  assign rst_q_n = rst_sync[1];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= `SBS_RESET_SYNC;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  // Open pins resolve through pulls
  assign sleep_lvl = sleep_connected & sleep_request; // [R4]
  assign strap_lvl = burst_order | ~burst_order_connected; // [R11]
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      sleep_sync <= 2'h0;
      oe_sync <= 2'h3;
      strap_sync <= 2'h3;
    end else begin
      sleep_sync <= {sleep_sync[0], sleep_lvl};
      oe_sync <= {oe_sync[0], output_enable_n};
      strap_sync <= {strap_sync[0], strap_lvl};
    end
  end
  reg [1:0] strap_wait;
  // Strap caught once, only after the synchroniser holds the pin level
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      interleave <= 1'b1;
      strap_taken <= 1'b0;
      strap_wait <= 2'h0;
    end else if (!strap_taken) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2) begin
        interleave <= strap_sync[1]; // [R10] [R11] [R12]
        strap_taken <= 1'b1;
      end
    end
  end
  assign pas = ~processor_address_strobe_n & ~chip_enable_n;
  assign cas = ~controller_address_strobe_n & ~pas; // [R2]
  assign cas_n = ~cas;
  assign strobe = (pas | cas) & ~sleep_sync[1];
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      addr_reg <= 19'h00000;
      selected <= 1'b0;
      was_deselected <= 1'b1;
      reading <= 1'b0;
    end else if (sleep_sync[1]) begin
      selected <= 1'b0; // [R3]
      reading <= 1'b0;
      was_deselected <= 1'b1;
    end else if (strobe) begin
      addr_reg <= addr; // [R1]
      selected <= ~chip_enable_n;
      was_deselected <= ~selected;
      reading <= ~chip_enable_n & (pas | write_enable_n);
    end else begin
      was_deselected <= ~selected;
    end
  end
  sbsram_burst u_burst (
    .clk(clk),
    .rst_q_n(rst_q_n),
    .load(strobe & ~cas_n | strobe & pas), // [R1]
    .load_val(addr[1:0]),
    .advance(~advance_n & selected & ~sleep_sync[1]),
    .interleave(interleave),
    .offset(offset)
  );
  assign cur_addr = {addr_reg[18:2], offset};
  // Write data registered on the edge
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      wdata_reg <= 16'h0000;
      wpar_reg <= 2'h0;
      lane_we <= 2'h0;
      wr_addr <= 19'h00000;
    end else begin
      wdata_reg <= data_in; // [R5]
      wpar_reg <= parity_data_lines_in; // [R9]
      lane_we <= (selected & ~write_enable_n & ~sleep_sync[1]) ?
        ~byte_lane_write_select_n : 2'h0; // [R9]
      wr_addr <= cur_addr;
    end
  end
  sbsram_mem u_lane0 (
    .clk(clk),
    .waddr(wr_addr),
    .wdata({wpar_reg[0], wdata_reg[7:0]}),
    .we(lane_we[0]),
    .raddr(cur_addr),
    .rdata(rd0)
  );
  sbsram_mem u_lane1 (
    .clk(clk),
    .waddr(wr_addr),
    .wdata({wpar_reg[1], wdata_reg[15:8]}),
    .we(lane_we[1]),
    .raddr(cur_addr),
    .rdata(rd1)
  );
  always @* begin
    next_drive = reading & selected & ~was_deselected & ~oe_sync[1]; // [R7] [R8]
  end
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      data_out <= 16'h0000;
      parity_data_lines_out <= 2'h0;
      data_oe_n <= 1'b1;
      parity_oe_n <= 1'b1;
      sleeping <= 1'b0;
    end else begin
      data_out <= {rd1[7:0], rd0[7:0]}; // [R6]
      parity_data_lines_out <= {rd1[8], rd0[8]}; // [R9]
      data_oe_n <= ~next_drive; // [R7]
      parity_oe_n <= ~next_drive; // [R9]
      sleeping <= sleep_sync[1]; // [R3]
    end
  end
endmodule

/* tb/sbsram_top_checker.sv */
`timescale 1ns/1ps
module sbsram_top_checker (
  input wire clk, rst_n, controller_address_strobe_n, processor_address_strobe_n,
  input wire chip_enable_n, output_enable_n, sleep_request, sleep_connected,
  input wire data_oe_n, parity_oe_n, sleeping
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire desel = chip_enable_n && !controller_address_strobe_n;
  wire idle = controller_address_strobe_n && processor_address_strobe_n;
  property p_oe; output_enable_n [*3] |=> data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("oe high");
  property p_par; parity_oe_n == data_oe_n; endproperty
  a_par: assert property (p_par) else $error("par oe");
  property p_ds; desel |-> ##3 data_oe_n; endproperty
  a_ds: assert property (p_ds) else $error("desel");
  property p_dsh; desel ##1 idle [*3] |=> data_oe_n; endproperty
  a_dsh: assert property (p_dsh) else $error("desel hold");
  property p_zz; (sleep_request && sleep_connected) [*4] |=> sleeping; endproperty
  a_zz: assert property (p_zz) else $error("no sleep");
  property p_wk; !sleep_request [*4] |=> !sleeping; endproperty
  a_wk: assert property (p_wk) else $error("no wake");
  property p_pd; !sleep_connected [*4] |=> !sleeping; endproperty
  a_pd: assert property (p_pd) else $error("open pin");
  property p_rs; disable iff (1'h0) !rst_n |=> data_oe_n && !sleeping; endproperty
  a_rs: assert property (p_rs) else $error("reset");
  c_rd: cover property (!data_oe_n);
  c_zz: cover property (sleeping);
  c_two: cover property (!controller_address_strobe_n && !processor_address_strobe_n);
endmodule
bind sbsram_top sbsram_top_checker chk (.*);

/* tb/sbsram_host.sv */
`timescale 1ns/1ps
module sbsram_host (
  input wire clk,
  output reg [18:0] addr = 19'h0,
  output reg controller_address_strobe_n = 1'h1,
  output reg processor_address_strobe_n = 1'h1,
  output reg advance_n = 1'h1,
  output reg chip_enable_n = 1'h1,
  output reg write_enable_n = 1'h1,
  output reg [1:0] byte_lane_write_select_n = 2'h3,
  output reg output_enable_n = 1'h1,
  output reg [17:0] host_data = 18'h0,
  output reg host_drive = 1'h0
);
  // Kind 0 read, 1 write, 2 deselect, 3 read on both strobes
  task start(input [1:0] k, input [18:0] a, input [17:0] d, input [1:0] l);
    begin
      @(negedge clk);
      output_enable_n = k == 2'h1;
      @(negedge clk);
      {addr, chip_enable_n, write_enable_n, advance_n} = {a, k == 2'h2, !k[0], 1'h1};
      controller_address_strobe_n = 1'h0;
      processor_address_strobe_n = k != 2'h3;
      @(negedge clk);
      {controller_address_strobe_n, processor_address_strobe_n, advance_n} = {2'h3, k == 2'h1};
      {host_data, host_drive, byte_lane_write_select_n} = {d, k == 2'h1, ~l};
      @(negedge clk);
      {write_enable_n, host_drive, byte_lane_write_select_n} = 4'hB;
    end
  endtask
endmodule

/* tb/sbsram_top_test.sv */
`timescale 1ns/1ps
module sbsram_top_test;
  reg clk = 1'h0, rst_n = 1'h0, sleep_request = 1'h0, sleep_connected = 1'h1;
  reg burst_order = 1'h0, burst_order_connected = 1'h1;
  wire [18:0] addr;
  wire [17:0] host_data;
  wire [15:0] data_in, data_out;
  wire [1:0] byte_lane_write_select_n, parity_data_lines_in, parity_data_lines_out;
  wire controller_address_strobe_n, processor_address_strobe_n, advance_n, chip_enable_n;
  wire write_enable_n, output_enable_n, host_drive, data_oe_n, parity_oe_n, sleeping;
  wire [17:0] q = {parity_data_lines_out, data_out};
  // Released pins show the inverse of the last level
  assign {parity_data_lines_in, data_in} = !data_oe_n ? q : host_drive ? host_data : ~q;
  integer n_mismatch = 0, compares = 0, cyc = 0, m, i, s;
  reg [17:0] mem [0:3];
  reg [17:0] d, k;
  reg [18:0] b;
  reg [1:0] l;
  sbsram_host host (.*);
  sbsram_top uut (.*);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 1500) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  function [1:0] ofs(input [1:0] st, input [1:0] n, input il);
    ofs = il ? st ^ n : st + n;
  endfunction
  task check(input [63:0] w, input [19:0] got, input [19:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s exp %h got %h", w, exp, got);
      end
    end
  endtask
  task rd(input [1:0] kind, input msk);
    begin
      host.start(kind, b + s, 18'h0, 2'h0);
      check("mask", {19'h0, data_oe_n}, {19'h0, msk});
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge clk);
        k = mem[ofs(s, i, m)];
        check("rd", {data_oe_n, parity_oe_n, q}, {2'h0, k});
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  initial begin
    m = $urandom(32'h61B1);
    for (m = 0; m < 2; m = m + 1) begin
      burst_order_connected = !m[0];
      rst_n = 1'h0;
      repeat (20) @(negedge clk);
      rst_n = 1'h1;
      repeat (4) @(negedge clk);
      b = $urandom;
      b[1:0] = 2'h0;
      for (i = 0; i < 4; i = i + 1) begin
        mem[i] = $urandom;
        host.start(2'h1, b + i, mem[i], 2'h3);
        d = $urandom;
        l = 2'h1 + $urandom % 3;
        host.start(2'h1, b + i, d, l);
        k = {l, {8{l[1]}}, {8{l[0]}}};
        mem[i] = (mem[i] & ~k) | (d & k);
      end
      s = m ? 3 : $urandom % 4;
      rd(m ? 2'h3 : 2'h0, 1'h0);
      host.start(2'h2, b, 18'h0, 2'h0);
      repeat (2) @(negedge clk);
      check("desel", data_oe_n, 1'h1);
      sleep_request = 1'h1;
      sleep_connected = !m[0];
      repeat (6) @(negedge clk);
      check("sleep", sleeping, !m[0]);
      d = ~mem[s];
      host.start(2'h1, b + s, d, 2'h3);
      if (m) mem[s] = d;
      sleep_request = 1'h0;
      repeat (6) @(negedge clk);
      rd(2'h0, !m[0]);
      $display("test mode %0d done", m);
    end
    close_out;
  end
endmodule
